// ### design/axis_drive_pkg.sv
package axis_drive_pkg;

  // Clock and the one-second tick.
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned NS_PER_SEC       = 1_000_000_000;
  localparam int unsigned TICK_CYCLES_DFLT = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int unsigned DIV_W            = 27;

  // Times in seconds, turned into counts of one-second ticks.
  localparam int unsigned SAFETY_HOLD_S   = 5;
  localparam int unsigned ELEV_TIMEOUT_MIN = 5;
  localparam int unsigned ELEV_TIMEOUT_S  = ELEV_TIMEOUT_MIN * 60;
  localparam int unsigned SEARCH_LEG_S    = 2;
  // One extra tick because the first tick after a stop may come at once.
  localparam logic [2:0] HOLD_TICKS   = 3'(SAFETY_HOLD_S + 1);
  localparam logic [8:0] EL_TMO_TICKS = 9'(ELEV_TIMEOUT_S);
  localparam logic [7:0] SEARCH_TICKS = 8'(SEARCH_LEG_S);

  localparam int unsigned POS_W = 16;
  localparam logic [POS_W-1:0] DEADBAND = 16'h0004;

  // Register offsets (byte addresses).
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_CFG      = 8'h04;
  localparam logic [7:0] ADDR_THRESH   = 8'h08;
  localparam logic [7:0] ADDR_AZ_TGT   = 8'h0c;
  localparam logic [7:0] ADDR_EL_TGT   = 8'h10;
  localparam logic [7:0] ADDR_POL_TGT  = 8'h14;
  localparam logic [7:0] ADDR_AZ_STOW  = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // Field positions.
  localparam int unsigned CMD_STOW_BIT    = 0;
  localparam int unsigned CMD_TGT_BIT     = 1;
  localparam int unsigned CMD_ABORT_BIT   = 2;
  localparam int unsigned CMD_FRST_LSB    = 4;
  localparam int unsigned CFG_POLSTOW_BIT = 0;
  localparam int unsigned CFG_STALL_LSB   = 8;
  localparam int unsigned CFG_RETRY_LSB   = 16;
  localparam int unsigned STAT_LIM_LSB    = 0;
  localparam int unsigned STAT_FAULT_LSB  = 8;
  localparam int unsigned STAT_STATE_LSB  = 16;
  localparam int unsigned STAT_SAFETY_BIT = 24;
  localparam int unsigned IRQ_JAM_LSB     = 0;
  localparam int unsigned IRQ_STOW_DONE   = 3;
  localparam int unsigned IRQ_STOW_FAIL   = 4;
  localparam int unsigned IRQ_EL_TMO      = 5;
  localparam int unsigned IRQ_W           = 6;

  // Reset values.
  localparam logic [7:0]       STALL_S_RST = 8'h04;
  localparam logic [3:0]       RETRY_RST   = 4'h3;
  localparam logic [POS_W-1:0] THRESH_RST  = 16'h0100;

  // Synchronised pin vector layout; jog keys follow relay order.
  localparam int unsigned PIN_AZ_STOW     = 0;
  localparam int unsigned PIN_EL_DOWN     = 1;
  localparam int unsigned PIN_EL_STOW     = 2;
  localparam int unsigned PIN_EL_UP       = 3;
  localparam int unsigned PIN_POL_STOW    = 4;
  localparam int unsigned PIN_AZ_CW_LIM   = 5;
  localparam int unsigned PIN_AZ_CCW_LIM  = 6;
  localparam int unsigned PIN_POL_CW_LIM  = 7;
  localparam int unsigned PIN_POL_CCW_LIM = 8;
  localparam int unsigned PIN_JOG_LSB     = 9;
  localparam int unsigned PIN_W           = 15;

  localparam int unsigned REL_AZ_CW   = 0;
  localparam int unsigned REL_AZ_CCW  = 1;
  localparam int unsigned REL_EL_UP   = 2;
  localparam int unsigned REL_EL_DN   = 3;
  localparam int unsigned REL_POL_CW  = 4;
  localparam int unsigned REL_POL_CCW = 5;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'b00001,
    ST_AZ_STOW   = 5'b00010,
    ST_AZ_SEARCH = 5'b00100,
    ST_EL_STOW   = 5'b01000,
    ST_TARGET    = 5'b10000
  } seq_e;

endpackage

// ### design/axis_stall_if.sv
`timescale 1ns/1ps
`default_nettype none
interface axis_stall_if;
  import axis_drive_pkg::*;
  logic             tick;
  logic             driving;
  logic [POS_W-1:0] pos;
  logic [7:0]       stall_s;
  logic             jam;
  modport det (input tick, input driving, input pos, input stall_s, output jam);
  modport ctl (output tick, output driving, output pos, output stall_s, input jam);
endinterface
`default_nettype wire

// ### design/axis_stall_det.sv
`timescale 1ns/1ps
`default_nettype none
module axis_stall_det
  import axis_drive_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst_n,
  axis_stall_if.det  bus
);

  typedef struct packed {
    logic [POS_W-1:0] last;
    logic [7:0]       secs;
    logic             jam;
  } det_s;

  det_s s;
  det_s next_s;

  always_comb begin
    next_s = s;
    next_s.jam = 1'b0;
    if (!bus.driving || bus.pos != s.last) begin
      next_s.last = bus.pos;
      next_s.secs = 8'h00;
    end else if (bus.tick) begin
      if (8'(s.secs + 8'h01) >= bus.stall_s) begin
        next_s.jam  = 1'b1;
        next_s.secs = 8'h00;
      end else begin
        next_s.secs = 8'(s.secs + 8'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.jam = s.jam;

  a_jam_while_driving: assert property (@(posedge clk) disable iff (!rst_n)
    s.jam |-> $past(bus.driving) && $past(bus.pos) == s.last)
    else $error("Jam raised without a steady driven axis.");

endmodule
`default_nettype wire

// ### design/antenna_axis_drive_supervisor.sv
// Summary of operation
// - Azimuth stow reports closed high; others low.
// - Elevation down shown alone only when unstowed.
// - Driven axis without position change flags jam.
// - Axis fault holds until explicit fault reset.
// - Jog energises relays only when limits allow.
// - Safety relay closed; opens 5 s after motion.
// - Jog key release drops drive relays at once.
// - Below down limit needs azimuth stow active.
// - Stow confirms azimuth switch, bounded nearby search.
// - Configured polarization stow switch also gates descent.
// - Stow drives elevation down until stow switch.
// - Elevation stow drive cut after 5 minutes.
// - Target moves fast when far, slow near.
// - Elevation stow forces elevation down condition.
// - Elevation down inhibits all azimuth motion.
// - Motion into CW/CCW limit inhibited, away allowed.
// - Faulted axis disabled until fault reset.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module antenna_axis_drive_supervisor
  import axis_drive_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  input  wire logic         az_stow_sw,
  input  wire logic         el_down_sw,
  input  wire logic         el_stow_sw,
  input  wire logic         el_up_sw,
  input  wire logic         pol_stow_sw,
  input  wire logic         az_cw_lim,
  input  wire logic         az_ccw_lim,
  input  wire logic         pol_cw_lim,
  input  wire logic         pol_ccw_lim,
  input  wire logic [5:0]   jog_key,
  input  wire logic [15:0]  az_pos,
  input  wire logic [15:0]  el_pos,
  input  wire logic [15:0]  pol_pos,
  output logic [5:0]        drive_relay,
  output logic              safety_relay,
  output logic [2:0]        fast_speed,
  output logic              irq
);

  typedef struct packed {
    logic [PIN_W-1:0]   pin_s1;
    logic [PIN_W-1:0]   pin_s2;
    logic [3*POS_W-1:0] pos_s1;
    logic [3*POS_W-1:0] pos_s2;
    logic [DIV_W-1:0]   div;
    logic               tick;
    seq_e               st;
    logic [3:0]         tries;
    logic [7:0]         leg_secs;
    logic               search_cw;
    logic [8:0]         el_secs;
    logic [2:0]         hold_secs;
    logic [2:0]         fault;
    logic [5:0]         relay;
    logic               safety;
    logic [2:0]         fast;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic               irq;
    logic               pol_stow_en;
    logic [7:0]         stall_s;
    logic [3:0]         retries;
    logic [POS_W-1:0]   thresh;
    logic [POS_W-1:0]   az_tgt;
    logic [POS_W-1:0]   el_tgt;
    logic [POS_W-1:0]   pol_tgt;
    logic [POS_W-1:0]   az_stow_pos;
    logic               aw_held;
    logic [7:0]         aw_addr;
    logic               w_held;
    logic [31:0]        wd;
    logic [3:0]         ws;
    logic               awready;
    logic               wready;
    logic               arready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } sup_s;

  localparam sup_s SUP_RST = '{default: '0, st: ST_IDLE, stall_s: STALL_S_RST,
                               retries: RETRY_RST, thresh: THRESH_RST};

  sup_s               s;
  sup_s               next_s;
  logic [PIN_W-1:0]   p;
  logic               el_down_cond;
  logic [4:0]         lim_stat;
  logic [5:0]         permit;
  logic [5:0]         auto_req;
  logic [5:0]         want;
  logic [2:0]         fast_req;
  logic [2:0]         jam;
  logic [2:0]         frst;
  logic [31:0]        cmd;
  logic [31:0]        wmask;
  logic [31:0]        merged;
  logic [32:0]        word;
  logic [IRQ_W-1:0]   irq_clr;
  logic [IRQ_W-1:0]   irq_set;
  logic [2:0]         sk_az;
  logic [2:0]         sk_el;
  logic [2:0]         sk_pol;
  logic               stop;

  // Returns {far, reverse, forward} for a move from pos toward tgt.
  function automatic logic [2:0] seek(input logic [POS_W-1:0] pos,
                                      input logic [POS_W-1:0] tgt,
                                      input logic [POS_W-1:0] thr);
    logic [POS_W-1:0] d;
    d = (tgt > pos) ? POS_W'(tgt - pos) : POS_W'(pos - tgt);
    seek = {d > thr, (d > DEADBAND) && (pos > tgt), (d > DEADBAND) && (tgt > pos)};
  endfunction

  // Returns {mapped, word} for a register address.
  function automatic logic [32:0] reg_word(input logic [7:0] a, input sup_s v,
                                           input logic [4:0] lim);
    logic [31:0] w;
    logic        ok;
    w  = 32'h0000_0000;
    ok = 1'b1;
    case (a)
      ADDR_CMD:      w = 32'h0000_0000;
      ADDR_CFG: begin
        w[CFG_POLSTOW_BIT]     = v.pol_stow_en;
        w[CFG_STALL_LSB +: 8]  = v.stall_s;
        w[CFG_RETRY_LSB +: 4]  = v.retries;
      end
      ADDR_THRESH:   w[POS_W-1:0] = v.thresh;
      ADDR_AZ_TGT:   w[POS_W-1:0] = v.az_tgt;
      ADDR_EL_TGT:   w[POS_W-1:0] = v.el_tgt;
      ADDR_POL_TGT:  w[POS_W-1:0] = v.pol_tgt;
      ADDR_AZ_STOW:  w[POS_W-1:0] = v.az_stow_pos;
      ADDR_STATUS: begin
        w[STAT_LIM_LSB +: 5]   = lim;
        w[STAT_FAULT_LSB +: 3] = v.fault;
        w[STAT_STATE_LSB +: 5] = v.st;
        w[STAT_SAFETY_BIT]     = v.safety;
      end
      ADDR_IRQ_STAT: w[IRQ_W-1:0] = v.irq_stat;
      ADDR_IRQ_MASK: w[IRQ_W-1:0] = v.irq_mask;
      default:       ok = 1'b0;
    endcase
    reg_word = {ok, w};
  endfunction

  always_comb begin
    next_s = s;
    p = s.pin_s2;
    next_s.pin_s1 = {jog_key, pol_ccw_lim, pol_cw_lim, az_ccw_lim, az_cw_lim,
                     pol_stow_sw, el_up_sw, el_stow_sw, el_down_sw, az_stow_sw};
    next_s.pin_s2 = s.pin_s1;
    next_s.pos_s1 = {pol_pos, el_pos, az_pos};
    next_s.pos_s2 = s.pos_s1;
    next_s.tick = 1'b0;
    if (s.div == DIV_W'(TICK_CYCLES - 1)) begin
      next_s.div  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 1'b1;
    end

    el_down_cond = p[PIN_EL_DOWN] | p[PIN_EL_STOW];
    lim_stat = {~p[PIN_POL_STOW], ~p[PIN_EL_UP], ~p[PIN_EL_STOW], ~el_down_cond,
                p[PIN_AZ_STOW]};
    permit[REL_AZ_CW]   = ~el_down_cond & ~p[PIN_AZ_CW_LIM] & ~s.fault[0];
    permit[REL_AZ_CCW]  = ~el_down_cond & ~p[PIN_AZ_CCW_LIM] & ~s.fault[0];
    permit[REL_EL_UP]   = ~p[PIN_EL_UP] & ~s.fault[1];
    permit[REL_EL_DN]   = ~p[PIN_EL_STOW] & ~s.fault[1] &
                          (~p[PIN_EL_DOWN] | (p[PIN_AZ_STOW] &
                           (p[PIN_POL_STOW] | ~s.pol_stow_en)));
    permit[REL_POL_CW]  = ~p[PIN_POL_CW_LIM] & ~s.fault[2];
    permit[REL_POL_CCW] = ~p[PIN_POL_CCW_LIM] & ~s.fault[2];

    // Register bus: address and data are taken in either order.
    cmd = 32'h0000_0000;
    irq_clr = '0;
    word = reg_word(s.aw_addr, s, lim_stat);
    wmask = {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}};
    merged = (word[31:0] & ~wmask) | (s.wd & wmask);
    if (awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wd = wdata;
      next_s.ws = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = word[32] ? RESP_OKAY : RESP_SLVERR;
      case (s.aw_addr)
        ADDR_CMD:      cmd = merged;
        ADDR_CFG: begin
          next_s.pol_stow_en = merged[CFG_POLSTOW_BIT];
          next_s.stall_s = merged[CFG_STALL_LSB +: 8];
          next_s.retries = merged[CFG_RETRY_LSB +: 4];
        end
        ADDR_THRESH:   next_s.thresh = merged[POS_W-1:0];
        ADDR_AZ_TGT:   next_s.az_tgt = merged[POS_W-1:0];
        ADDR_EL_TGT:   next_s.el_tgt = merged[POS_W-1:0];
        ADDR_POL_TGT:  next_s.pol_tgt = merged[POS_W-1:0];
        ADDR_AZ_STOW:  next_s.az_stow_pos = merged[POS_W-1:0];
        ADDR_IRQ_STAT: irq_clr = s.wd[IRQ_W-1:0] & wmask[IRQ_W-1:0];
        ADDR_IRQ_MASK: next_s.irq_mask = merged[IRQ_W-1:0];
        default:       cmd = 32'h0000_0000;
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      word = reg_word(araddr, s, lim_stat);
      next_s.rvalid = 1'b1;
      next_s.rdata = word[31:0];
      next_s.rresp = word[32] ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    frst = cmd[CMD_FRST_LSB +: 3];

    // Automatic sequences.
    auto_req = '0;
    fast_req = '0;
    irq_set = '0;
    sk_az = seek(s.pos_s2[0 +: POS_W], (s.st == ST_TARGET) ? s.az_tgt : s.az_stow_pos,
                 s.thresh);
    sk_el = seek(s.pos_s2[POS_W +: POS_W], s.el_tgt, s.thresh);
    sk_pol = seek(s.pos_s2[2*POS_W +: POS_W], s.pol_tgt, s.thresh);
    case (s.st)
      ST_IDLE: begin
        if (cmd[CMD_STOW_BIT]) begin
          next_s.st = ST_AZ_STOW;
        end else if (cmd[CMD_TGT_BIT]) begin
          next_s.st = ST_TARGET;
        end
      end
      ST_AZ_STOW: begin
        auto_req[REL_AZ_CW +: 2] = sk_az[1:0];
        fast_req[0] = sk_az[2];
        if (sk_az[1:0] == 2'b00) begin
          next_s.tries = 4'h0;
          next_s.leg_secs = 8'h00;
          next_s.search_cw = 1'b1;
          next_s.el_secs = 9'h000;
          next_s.st = p[PIN_AZ_STOW] ? ST_EL_STOW : ST_AZ_SEARCH;
        end
      end
      ST_AZ_SEARCH: begin
        // Each leg is longer than the last so the sweep widens around the stow point.
        auto_req[REL_AZ_CW] = s.search_cw;
        auto_req[REL_AZ_CCW] = ~s.search_cw;
        if (p[PIN_AZ_STOW]) begin
          next_s.el_secs = 9'h000;
          next_s.st = ST_EL_STOW;
        end else if (s.tick) begin
          if (8'(s.leg_secs + 8'h01) >= 8'(SEARCH_TICKS * (8'(s.tries) + 8'h01))) begin
            next_s.leg_secs = 8'h00;
            next_s.search_cw = ~s.search_cw;
            next_s.tries = 4'(s.tries + 4'h1);
            if (4'(s.tries + 4'h1) >= s.retries) begin
              irq_set[IRQ_STOW_FAIL] = 1'b1;
              next_s.st = ST_IDLE;
            end
          end else begin
            next_s.leg_secs = 8'(s.leg_secs + 8'h01);
          end
        end
      end
      ST_EL_STOW: begin
        auto_req[REL_EL_DN] = 1'b1;
        fast_req[1] = ~el_down_cond;
        if (p[PIN_EL_STOW]) begin
          irq_set[IRQ_STOW_DONE] = 1'b1;
          next_s.st = ST_IDLE;
        end else if (s.tick) begin
          next_s.el_secs = 9'(s.el_secs + 9'h001);
          if (9'(s.el_secs + 9'h001) >= EL_TMO_TICKS) begin
            irq_set[IRQ_EL_TMO] = 1'b1;
            next_s.el_secs = 9'h000;
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_TARGET: begin
        auto_req = {sk_pol[1:0], sk_el[1:0], sk_az[1:0]};
        fast_req = {sk_pol[2], sk_el[2], sk_az[2]};
        if (auto_req == 6'h00) begin
          next_s.st = ST_IDLE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    stop = (s.st != ST_IDLE) && (cmd[CMD_ABORT_BIT] || (|s.fault));
    if (stop) begin
      next_s.st = ST_IDLE;
      auto_req = '0;
    end

    // Jog keys act only while idle; releasing a key drops its relay on the third edge, after the two synchroniser stages.
    want = (s.st == ST_IDLE) ? p[PIN_JOG_LSB +: 6] : auto_req;
    for (int g = 0; g < 3; g++) begin
      if (want[2*g] && want[2*g+1]) begin
        want[2*g +: 2] = 2'b00;
      end
    end
    next_s.relay = want & permit;
    next_s.fast = fast_req & {|next_s.relay[5:4], |next_s.relay[3:2], |next_s.relay[1:0]};

    if (|next_s.relay) begin
      next_s.safety = 1'b1;
      next_s.hold_secs = 3'h0;
    end else if (s.safety && s.tick) begin
      if (3'(s.hold_secs + 3'h1) >= HOLD_TICKS) begin
        next_s.safety = 1'b0;
        next_s.hold_secs = 3'h0;
      end else begin
        next_s.hold_secs = 3'(s.hold_secs + 3'h1);
      end
    end

    // A fault or status event in the clearing cycle still sets its bit.
    next_s.fault = (s.fault & ~frst) | jam;
    irq_set[IRQ_JAM_LSB +: 3] = jam;
    next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= SUP_RST;
    end else begin
      s <= next_s;
    end
  end

  axis_stall_if stall_bus[3] ();
  for (genvar g = 0; g < 3; g++) begin : g_stall
    assign stall_bus[g].tick = s.tick;
    assign stall_bus[g].driving = s.relay[2*g] | s.relay[2*g+1];
    assign stall_bus[g].pos = s.pos_s2[g*POS_W +: POS_W];
    assign stall_bus[g].stall_s = s.stall_s;
    assign jam[g] = stall_bus[g].jam;
    axis_stall_det u_det (
      .clk   (clk),
      .rst_n (rst_n),
      .bus   (stall_bus[g])
    );
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign arready = s.arready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign drive_relay = s.relay;
  assign safety_relay = s.safety;
  assign fast_speed = s.fast;
  assign irq = s.irq;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_lim_polarity: assert property (lim_stat[0] == p[PIN_AZ_STOW] &&
    lim_stat[3] != p[PIN_EL_UP]) else $error("Limit status polarity wrong.");
  a_stow_forces_down: assert property (p[PIN_EL_STOW] |-> !lim_stat[1])
    else $error("Elevation stow did not force the down report.");
  a_jam_latches: assert property (jam[1] |=> s.fault[1])
    else $error("Jam did not latch a fault.");
  a_fault_holds: assert property (s.fault[0] && !frst[0] |=> s.fault[0])
    else $error("Fault cleared without a reset.");
  a_az_inhibit: assert property (s.relay[REL_AZ_CW] |-> !$past(el_down_cond) &&
    !$past(p[PIN_AZ_CW_LIM])) else $error("Azimuth drove into an inhibit.");
  a_safety_covers: assert property (|s.relay |-> s.safety)
    else $error("Drive relay on without safety relay.");
  a_jog_release: assert property (s.st == ST_IDLE && !p[PIN_JOG_LSB + REL_EL_UP]
    |=> !s.relay[REL_EL_UP]) else $error("Released jog kept relay on.");
  a_descent_gate: assert property (s.relay[REL_EL_DN] && $past(p[PIN_EL_DOWN]) |->
    $past(p[PIN_AZ_STOW])) else $error("Descent below down limit without azimuth stow.");
  a_el_timeout: assert property (s.el_secs < EL_TMO_TICKS)
    else $error("Elevation stow drive ran past its timeout.");
  a_fault_blocks: assert property (s.fault[2] |=> s.relay[5:4] == 2'b00)
    else $error("Faulted axis still driven.");

endmodule
`default_nettype wire

// ### tb/mount_model.sv
`timescale 1ns/1ps
`default_nettype none
module mount_model (
  input  wire logic        clk,
  input  wire logic [5:0]  drive_relay,
  input  wire logic        safety_relay,
  input  wire logic        stuck,
  output logic      [15:0] az_pos,
  output logic      [15:0] el_pos,
  output logic      [15:0] pol_pos
);
  // Motors turn only while the series safety relay is closed; a stuck mount never moves.
  initial {az_pos, el_pos, pol_pos} = {3{16'h8000}};
  always @(posedge clk) begin
    if (safety_relay && !stuck) begin
      az_pos  <= az_pos + 16'(drive_relay[0]) - 16'(drive_relay[1]);
      el_pos  <= el_pos + 16'(drive_relay[2]) - 16'(drive_relay[3]);
      pol_pos <= pol_pos + 16'(drive_relay[4]) - 16'(drive_relay[5]);
    end
  end
endmodule
`default_nettype wire

// ### tb/antenna_axis_drive_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module antenna_axis_drive_supervisor_tb;
  import axis_drive_pkg::*;
  localparam int TC = 20;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, stuck;
  logic        awready, wready, bvalid, arready, rvalid, safety_relay, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [8:0]  sw;
  logic [5:0]  jog_key, drive_relay;
  logic [2:0]  fast_speed;
  logic [15:0] az_pos, el_pos, pol_pos;
  int          err_total, n_compared, cyc;

  antenna_axis_drive_supervisor #(.TICK_CYCLES(TC)) antenna_axis_drive_supervisor_i (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .az_stow_sw(sw[0]), .el_down_sw(sw[1]), .el_stow_sw(sw[2]), .el_up_sw(sw[3]),
    .pol_stow_sw(sw[4]), .az_cw_lim(sw[5]), .az_ccw_lim(sw[6]), .pol_cw_lim(sw[7]),
    .pol_ccw_lim(sw[8]), .jog_key(jog_key), .az_pos(az_pos), .el_pos(el_pos),
    .pol_pos(pol_pos), .drive_relay(drive_relay), .safety_relay(safety_relay),
    .fast_speed(fast_speed), .irq(irq));
  mount_model mount_model_i (.clk(clk), .drive_relay(drive_relay),
    .safety_relay(safety_relay), .stuck(stuck), .az_pos(az_pos), .el_pos(el_pos),
    .pol_pos(pol_pos));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask

  // Relays answer three edges after a pin change, so five cycles is settled.
  task automatic jog(input logic [8:0] s, input logic [5:0] j, input logic [5:0] e);
    sw <= s;
    jog_key <= j;
    repeat (5) @(posedge clk);
    chk(32'(drive_relay), 32'(e));
  endtask

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, stuck} <= '0;
    {awaddr, araddr, wdata, sw, jog_key} <= '0;
    wstrb <= 4'hf;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(ADDR_STATUS, 32'h011f_071f, 32'h0001_001e);
    sw <= 9'h01f;
    repeat (3) @(posedge clk);
    rchk(ADDR_STATUS, 32'h1f, 32'h01);
    sw <= 9'h004;
    repeat (3) @(posedge clk);
    rchk(ADDR_STATUS, 32'h1f, 32'h18);
    jog(9'h004, 6'h01, 6'h00);
    jog(9'h020, 6'h01, 6'h00);
    jog(9'h020, 6'h02, 6'h02);
    chk(32'(safety_relay), 32'h1);
    jog(9'h020, 6'h00, 6'h00);
    repeat (3 * TC) @(posedge clk);
    chk(32'(safety_relay), 32'h1);
    repeat (4 * TC) @(posedge clk);
    chk(32'(safety_relay), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1);
    stuck <= 1'b1;
    jog(9'h000, 6'h02, 6'h02);
    repeat (6 * TC) @(posedge clk);
    chk(32'(drive_relay), 32'h0);
    chk(32'(irq), 32'h1);
    rchk(ADDR_STATUS, 32'h700, 32'h100);
    stuck <= 1'b0;
    jog(9'h000, 6'h00, 6'h00);
    jog(9'h000, 6'h02, 6'h00);
    jog(9'h000, 6'h00, 6'h00);
    wr(ADDR_CMD, 32'h10);
    wr(ADDR_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    rchk(ADDR_STATUS, 32'h700, 32'h000);
    jog(9'h000, 6'h02, 6'h02);
    jog(9'h000, 6'h00, 6'h00);
    wr(ADDR_CFG, 32'h0003_0401);
    jog(9'h002, 6'h08, 6'h00);
    jog(9'h003, 6'h08, 6'h00);
    jog(9'h013, 6'h08, 6'h08);
    jog(9'h013, 6'h00, 6'h00);
    // Stow with the azimuth switch open: fast then slow approach, then a failed search.
    sw <= 9'h000;
    wr(ADDR_THRESH, 32'h10);
    wr(ADDR_AZ_STOW, 32'(az_pos) + 32'h20);
    wr(ADDR_CMD, 32'h1);
    repeat (4) @(posedge clk);
    chk(32'({fast_speed, drive_relay}), 32'h41);
    repeat (20) @(posedge clk);
    chk(32'({fast_speed, drive_relay}), 32'h01);
    repeat (400) @(posedge clk);
    rchk(ADDR_IRQ_STAT, 32'h38, 32'h10);
    // Switch found, but the elevation stow switch stays open past the timeout; it closes on a second stow.
    sw <= 9'h001;
    wr(ADDR_CMD, 32'h1);
    repeat (1000) @(posedge clk);
    chk(32'({fast_speed, drive_relay}), 32'h88);
    repeat (5300) @(posedge clk);
    chk(32'(drive_relay), 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h38, 32'h30);
    wr(ADDR_CMD, 32'h1);
    repeat (100) @(posedge clk);
    chk(32'(drive_relay), 32'h08);
    sw <= 9'h005;
    repeat (5) @(posedge clk);
    chk(32'(drive_relay), 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h38, 32'h38);
    // Abort a running search, then a short target move at slow speed.
    sw <= 9'h000;
    wr(ADDR_CMD, 32'h1);
    rchk(ADDR_STATUS, 32'h1f0000, 32'h40000);
    wr(ADDR_CMD, 32'h4);
    rchk(ADDR_STATUS, 32'h1f0000, 32'h10000);
    chk(32'(drive_relay), 32'h0);
    wr(ADDR_AZ_TGT, 32'(az_pos) + 32'hc);
    wr(ADDR_EL_TGT, 32'(el_pos) + 32'hc);
    wr(ADDR_POL_TGT, 32'(pol_pos) + 32'hc);
    wr(ADDR_CMD, 32'h2);
    repeat (4) @(posedge clk);
    chk(32'({fast_speed, drive_relay}), 32'h015);
    repeat (30) @(posedge clk);
    rchk(ADDR_STATUS, 32'h1f0000, 32'h10000);
    wr(8'h40, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    rd(8'h40);
    chk(d, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    final_report();
  end
endmodule
`default_nettype wire
